// ===== design/vegss_pkg.sv
package vegss_pkg;

   // segment slots
   localparam int unsigned NUM_SEGS = 8;
   localparam logic [2:0] SEG_CODE = 3'h0;
   localparam logic [2:0] SEG_STACK = 3'h1;
   localparam logic [2:0] SEG_DATA = 3'h2;
   localparam logic [2:0] SEG_EXTRA = 3'h3;
   localparam logic [2:0] SEG_AUX_ONE = 3'h4;
   localparam logic [2:0] SEG_AUX_TWO = 3'h5;
   localparam logic [2:0] SEG_LDT = 3'h6;
   localparam logic [2:0] SEG_TASK = 3'h7;

   // guest-state field numbers on the field write port
   localparam logic [5:0] FLD_CR_ZERO = 6'h00;
   localparam logic [5:0] FLD_PT_BASE = 6'h01;
   localparam logic [5:0] FLD_CR_FOUR = 6'h02;
   localparam logic [5:0] FLD_FC_CODE = 6'h03;
   localparam logic [5:0] FLD_FC_STACK = 6'h04;
   localparam logic [5:0] FLD_FC_ENTRY = 6'h05;
   localparam logic [5:0] FLD_DBG_REG = 6'h06;
   localparam logic [5:0] FLD_DBG_MSR = 6'h07;
   localparam logic [5:0] FLD_PAGE_ATTR = 6'h08;
   localparam logic [5:0] FLD_EXT_FEAT = 6'h09;
   localparam logic [5:0] FLD_MM_BASE = 6'h0A;
   localparam logic [5:0] FLD_GDT_BASE = 6'h0B;
   localparam logic [5:0] FLD_GDT_LIMIT = 6'h0C;
   localparam logic [5:0] FLD_IDT_BASE = 6'h0D;
   localparam logic [5:0] FLD_IDT_LIMIT = 6'h0E;
   localparam logic [5:0] FLD_INSTR_PTR = 6'h0F;
   localparam logic [5:0] FLD_STACK_PTR = 6'h10;
   localparam logic [5:0] FLD_FLAGS = 6'h11;
   // segment k: base, limit, access rights at SEG_FLD_BASE + 3k + {0,1,2}
   localparam logic [5:0] SEG_FLD_BASE = 6'h12;
   localparam logic [5:0] SEG_FLD_STRIDE = 6'h03;
   localparam logic [1:0] SEG_KIND_BASE = 2'h0;
   localparam logic [1:0] SEG_KIND_LIMIT = 2'h1;
   localparam logic [1:0] SEG_KIND_AR = 2'h2;
   localparam logic [5:0] FLD_LAST = 6'h29;

   localparam int unsigned RESUME_FLAG_BIT = 16;
   localparam int unsigned CANON_TOP_BIT = 47;

   // register map
   localparam logic [7:0] ADDR_CTRL = 8'h00;
   localparam logic [7:0] ADDR_STATUS = 8'h04;
   localparam logic [7:0] ADDR_EXITS = 8'h08;
   localparam int unsigned CTRL_SAVE_DBG = 0;
   localparam int unsigned CTRL_SAVE_PAT = 1;
   localparam int unsigned CTRL_SAVE_EFER = 2;
   localparam logic [2:0] CTRL_RST = 3'h7;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   typedef enum logic [3:0] {
      CAUSE_INSTR,
      CAUSE_INIT_STARTUP_INTERPROCESSOR_INTERRUPT_MGMT,
      CAUSE_WINDOW,
      CAUSE_EVENT,
      CAUSE_TRIPLE,
      CAUSE_SW_EXC,
      CAUSE_TASK_INSTR,
      CAUSE_TASK_GATE,
      CAUSE_PRIO_DROP,
      CAUSE_APIC_WRITE,
      CAUSE_APIC_ACCESS,
      CAUSE_NPT,
      CAUSE_OTHER
   } vegss_cause_e;

   typedef enum logic {
      SEQ_IDLE,
      SEQ_RUN
   } vegss_seq_e;

endpackage : vegss_pkg

// ===== design/vegss_top.sv
// The register offsets and register access over AXI4-Lite were left to the implementer.
`timescale 1ns/100ps
// How it works
// [RL1] every exit copies control regs and fast-call MSRs
// [RL2] fast-call selector upper half never saved
// [RL3] debug, attribute, feature MSRs gated by controls
// [RL4] management base written only on management exits
// [RL5] unusable segment fields may be undefined
// [RL6] code segment base, limit, size bits saved
// [RL7] stack segment privilege kept, upper base zero
// [RL8] data/extra upper zero, aux bases, canonical table
// [RL9] usable segment base, limit, rights saved unchanged
// [RL10] rights 31:17, 11:8 clear; bit16 means unusable
// [RL11] descriptor table bases and limits always saved
// [RL12] exiting instruction: pointer references that instruction
// [RL13] reset, startup, management interrupt: prior pointer
// [RL14] window exits: pointer as if no exit
// [RL15] events save delivery return pointer, triple double-fault
// [RL16] breakpoint/task instruction: causing instruction; gates: outgoing
// [RL17] priority drop, write emulation: following instruction
// [RL18] stack pointer, flags saved unchanged except resume
// [RL19] vectored, triple, task: resume as delivery records
// [RL20] exiting instruction saves resume flag zero
// [RL21] access/nested faults: resume one unless vectoring
// [RL22] otherwise resume flag kept as before
module vegss_top
   import vegss_pkg::*;
#(
   parameter bit LONG_MODE = 1'b1
) (
   input wire logic i_core_clk,
   input wire logic i_sys_rst,
   input wire logic [7:0] i_s_axi_awaddr,
   input wire logic i_s_axi_awvalid,
   output logic o_s_axi_awready,
   input wire logic [31:0] i_s_axi_wdata,
   input wire logic [3:0] i_s_axi_wstrb,
   input wire logic i_s_axi_wvalid,
   output logic o_s_axi_wready,
   output logic [1:0] o_s_axi_bresp,
   output logic o_s_axi_bvalid,
   input wire logic i_s_axi_bready,
   input wire logic [7:0] i_s_axi_araddr,
   input wire logic i_s_axi_arvalid,
   output logic o_s_axi_arready,
   output logic [31:0] o_s_axi_rdata,
   output logic [1:0] o_s_axi_rresp,
   output logic o_s_axi_rvalid,
   input wire logic i_s_axi_rready,
   input wire logic i_exit_start,
   input wire logic [3:0] i_exit_cause,
   input wire logic i_mm_exit,
   input wire logic i_vect_info_valid,
   input wire logic [63:0] i_control_reg_zero,
   input wire logic [63:0] i_page_table_base_reg,
   input wire logic [63:0] i_control_reg_four,
   input wire logic [63:0] i_fast_call_code_selector,
   input wire logic [63:0] i_fast_call_stack_pointer,
   input wire logic [63:0] i_fast_call_entry_pointer,
   input wire logic [63:0] i_debug_control_reg,
   input wire logic [63:0] i_debug_control_msr,
   input wire logic [63:0] i_page_attribute_msr,
   input wire logic [63:0] i_extended_feature_enable_msr,
   input wire logic [63:0] i_management_mode_base,
   input wire logic [63:0] i_seg_base [NUM_SEGS],
   input wire logic [31:0] i_seg_limit [NUM_SEGS],
   input wire logic [31:0] i_seg_ar [NUM_SEGS],
   input wire logic [NUM_SEGS-1:0] i_seg_unusable,
   input wire logic [63:0] i_gdt_base,
   input wire logic [31:0] i_gdt_limit,
   input wire logic [63:0] i_idt_base,
   input wire logic [31:0] i_idt_limit,
   input wire logic [63:0] i_instruction_pointer,
   input wire logic [63:0] i_instruction_pointer_next,
   input wire logic [63:0] i_instruction_pointer_return,
   input wire logic [63:0] i_stack_pointer,
   input wire logic [63:0] i_flags_register,
   input wire logic i_resume_flag_delivered,
   output logic o_fld_valid,
   output logic [5:0] o_fld_idx,
   output logic [63:0] o_fld_data,
   output logic o_busy,
   output logic o_done
);

   localparam int EXIT_DONE_DELAY = 43;

   function automatic logic [2:0] seg_of(input logic [5:0] idx);
      logic [5:0] off;
      off = idx - SEG_FLD_BASE;
      return 3'(off / SEG_FLD_STRIDE);
   endfunction : seg_of

   function automatic logic [1:0] kind_of(input logic [5:0] idx);
      logic [5:0] off;
      off = idx - SEG_FLD_BASE;
      return 2'(off % SEG_FLD_STRIDE);
   endfunction : kind_of

   vegss_seq_e seq_reg;
   logic [5:0] idx_reg;
   vegss_cause_e cause_reg;
   logic mm_reg;
   logic vect_reg;
   logic [2:0] save_reg;
   logic [2:0] ctrl_reg;
   logic [15:0] exits_reg;
   logic aw_rdy_reg;
   logic ar_rdy_reg;
   logic [63:0] sv_base [NUM_SEGS];
   logic [31:0] sv_ar [NUM_SEGS];
   logic [63:0] rip_next;
   logic rf_next;
   logic [63:0] fld_data_next;
   logic fld_en_next;

   // per-segment saved base and access rights
   for (genvar k = 0; k < NUM_SEGS; k++) begin : g_seg
      always_comb begin
         sv_base[k] = i_seg_base[k]; // RL9 RL6
         if (i_seg_unusable[k] && LONG_MODE) begin
            if (3'(k) == SEG_STACK || 3'(k) == SEG_DATA || 3'(k) == SEG_EXTRA) begin
               sv_base[k][63:32] = 32'h0000_0000; // RL7 RL8
            end else if (3'(k) == SEG_LDT) begin
               sv_base[k][63:CANON_TOP_BIT+1] = {(63-CANON_TOP_BIT){i_seg_base[k][CANON_TOP_BIT]}}; // RL8
            end
         end
         // unusable segments keep the held bits, which covers the code size bits and stack privilege; the base exceptions are handled above
         sv_ar[k] = {15'h0000, i_seg_unusable[k], i_seg_ar[k][15:12], 4'h0,
                     i_seg_ar[k][7:0]}; // RL10 RL9 RL5 RL6 RL7
      end
   end

   always_comb begin
      case (cause_reg)
         CAUSE_INSTR, CAUSE_SW_EXC, CAUSE_TASK_INSTR: rip_next = i_instruction_pointer; // RL12 RL16
         CAUSE_INIT_STARTUP_INTERPROCESSOR_INTERRUPT_MGMT: rip_next = i_instruction_pointer; // RL13
         CAUSE_WINDOW: rip_next = i_instruction_pointer; // RL14
         CAUSE_EVENT, CAUSE_TRIPLE: rip_next = i_instruction_pointer_return; // RL15
         CAUSE_TASK_GATE: rip_next = i_instruction_pointer_return; // RL16
         CAUSE_PRIO_DROP, CAUSE_APIC_WRITE: rip_next = i_instruction_pointer_next; // RL17
         default: rip_next = i_instruction_pointer;
      endcase
   end

   always_comb begin
      case (cause_reg)
         CAUSE_EVENT, CAUSE_TRIPLE, CAUSE_SW_EXC, CAUSE_TASK_INSTR, CAUSE_TASK_GATE: begin
            rf_next = i_resume_flag_delivered; // RL19
         end
         CAUSE_INSTR: rf_next = 1'h0; // RL20
         CAUSE_APIC_ACCESS, CAUSE_NPT: begin
            rf_next = vect_reg ? i_resume_flag_delivered : 1'h1; // RL21
         end
         default: rf_next = i_flags_register[RESUME_FLAG_BIT]; // RL22
      endcase
   end

   // field value and whether it is written this exit
   always_comb begin
      fld_en_next = 1'h1;
      fld_data_next = 64'h0000_0000_0000_0000;
      case (idx_reg)
         FLD_CR_ZERO: fld_data_next = i_control_reg_zero; // RL1
         FLD_PT_BASE: fld_data_next = i_page_table_base_reg; // RL1
         FLD_CR_FOUR: fld_data_next = i_control_reg_four; // RL1
         FLD_FC_CODE: fld_data_next = {32'h0000_0000, i_fast_call_code_selector[31:0]}; // RL2
         FLD_FC_STACK: begin
            fld_data_next = i_fast_call_stack_pointer; // RL1
            if (!LONG_MODE) fld_data_next[63:32] = 32'h0000_0000; // RL2
         end
         FLD_FC_ENTRY: begin
            fld_data_next = i_fast_call_entry_pointer; // RL1
            if (!LONG_MODE) fld_data_next[63:32] = 32'h0000_0000; // RL2
         end
         FLD_DBG_REG: begin
            fld_data_next = i_debug_control_reg;
            fld_en_next = save_reg[CTRL_SAVE_DBG]; // RL3
         end
         FLD_DBG_MSR: begin
            fld_data_next = i_debug_control_msr;
            fld_en_next = save_reg[CTRL_SAVE_DBG]; // RL3
         end
         FLD_PAGE_ATTR: begin
            fld_data_next = i_page_attribute_msr;
            fld_en_next = save_reg[CTRL_SAVE_PAT]; // RL3
         end
         FLD_EXT_FEAT: begin
            fld_data_next = i_extended_feature_enable_msr;
            fld_en_next = save_reg[CTRL_SAVE_EFER]; // RL3
         end
         FLD_MM_BASE: begin
            fld_data_next = i_management_mode_base;
            fld_en_next = mm_reg; // RL4
         end
         FLD_GDT_BASE: fld_data_next = i_gdt_base; // RL11
         FLD_GDT_LIMIT: fld_data_next = {32'h0000_0000, i_gdt_limit}; // RL11
         FLD_IDT_BASE: fld_data_next = i_idt_base; // RL11
         FLD_IDT_LIMIT: fld_data_next = {32'h0000_0000, i_idt_limit}; // RL11
         FLD_INSTR_PTR: fld_data_next = rip_next;
         FLD_STACK_PTR: fld_data_next = i_stack_pointer; // RL18
         FLD_FLAGS: begin
            fld_data_next = i_flags_register; // RL18
            fld_data_next[RESUME_FLAG_BIT] = rf_next;
         end
         default: begin
            if (kind_of(idx_reg) == SEG_KIND_BASE) begin
               fld_data_next = sv_base[seg_of(idx_reg)];
            end else if (kind_of(idx_reg) == SEG_KIND_LIMIT) begin
               fld_data_next = {32'h0000_0000, i_seg_limit[seg_of(idx_reg)]};
            end else begin
               fld_data_next = {32'h0000_0000, sv_ar[seg_of(idx_reg)]};
            end
         end
      endcase
   end

   // save sequencer: one field per cycle; a start while busy is ignored
   always_ff @(posedge i_core_clk or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         seq_reg <= SEQ_IDLE;
         idx_reg <= FLD_CR_ZERO;
         cause_reg <= CAUSE_OTHER;
         mm_reg <= 1'h0;
         vect_reg <= 1'h0;
         save_reg <= CTRL_RST;
         o_busy <= 1'h0;
         o_done <= 1'h0;
      end else begin
         o_done <= 1'h0;
         case (seq_reg)
            SEQ_IDLE: begin
               if (i_exit_start) begin
                  seq_reg <= SEQ_RUN;
                  idx_reg <= FLD_CR_ZERO;
                  cause_reg <= vegss_cause_e'(i_exit_cause);
                  mm_reg <= i_mm_exit;
                  vect_reg <= i_vect_info_valid;
                  save_reg <= ctrl_reg;
                  o_busy <= 1'h1;
               end
            end
            SEQ_RUN: begin
               if (idx_reg == FLD_LAST) begin
                  seq_reg <= SEQ_IDLE;
                  o_busy <= 1'h0;
                  o_done <= 1'h1;
               end else begin
                  idx_reg <= idx_reg + 6'h01;
               end
            end
            default: seq_reg <= SEQ_IDLE;
         endcase
      end
   end

   always_ff @(posedge i_core_clk or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         o_fld_valid <= 1'h0;
         o_fld_idx <= FLD_CR_ZERO;
         o_fld_data <= 64'h0000_0000_0000_0000;
      end else begin
         o_fld_valid <= (seq_reg == SEQ_RUN) && fld_en_next;
         o_fld_idx <= idx_reg;
         o_fld_data <= fld_data_next;
      end
   end

   always_ff @(posedge i_core_clk or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         exits_reg <= 16'h0000;
      end else if (o_done) begin
         exits_reg <= exits_reg + 16'h0001;
      end
   end

   // axi4-lite write: address and data taken together
   always_ff @(posedge i_core_clk or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         aw_rdy_reg <= 1'h0;
         o_s_axi_bvalid <= 1'h0;
         o_s_axi_bresp <= RESP_OKAY;
         ctrl_reg <= CTRL_RST;
      end else begin
         if (aw_rdy_reg) begin
            aw_rdy_reg <= 1'h0;
            o_s_axi_bvalid <= 1'h1;
            if (i_s_axi_awaddr == ADDR_CTRL) begin
               if (i_s_axi_wstrb[0]) ctrl_reg <= i_s_axi_wdata[2:0];
               o_s_axi_bresp <= RESP_OKAY;
            end else if (i_s_axi_awaddr == ADDR_STATUS || i_s_axi_awaddr == ADDR_EXITS) begin
               o_s_axi_bresp <= RESP_OKAY;
            end else begin
               o_s_axi_bresp <= RESP_SLVERR;
            end
         end else if (i_s_axi_awvalid && i_s_axi_wvalid && !o_s_axi_bvalid) begin
            aw_rdy_reg <= 1'h1;
         end
         if (o_s_axi_bvalid && i_s_axi_bready) o_s_axi_bvalid <= 1'h0;
      end
   end

   assign o_s_axi_awready = aw_rdy_reg;
   assign o_s_axi_wready = aw_rdy_reg;

   // axi4-lite read
   always_ff @(posedge i_core_clk or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         ar_rdy_reg <= 1'h0;
         o_s_axi_rvalid <= 1'h0;
         o_s_axi_rresp <= RESP_OKAY;
         o_s_axi_rdata <= 32'h0000_0000;
      end else begin
         if (ar_rdy_reg) begin
            ar_rdy_reg <= 1'h0;
            o_s_axi_rvalid <= 1'h1;
            o_s_axi_rresp <= RESP_OKAY;
            if (i_s_axi_araddr == ADDR_CTRL) begin
               o_s_axi_rdata <= {29'h0000_0000, ctrl_reg};
            end else if (i_s_axi_araddr == ADDR_STATUS) begin
               o_s_axi_rdata <= {26'h000_0000, o_busy, mm_reg, cause_reg};
            end else if (i_s_axi_araddr == ADDR_EXITS) begin
               o_s_axi_rdata <= {16'h0000, exits_reg};
            end else begin
               o_s_axi_rdata <= 32'h0000_0000;
               o_s_axi_rresp <= RESP_SLVERR;
            end
         end else if (i_s_axi_arvalid && !o_s_axi_rvalid) begin
            ar_rdy_reg <= 1'h1;
         end
         if (o_s_axi_rvalid && i_s_axi_rready) o_s_axi_rvalid <= 1'h0;
      end
   end

   assign o_s_axi_arready = ar_rdy_reg;

   default clocking @(posedge i_core_clk); endclocking
   default disable iff (i_sys_rst);

   logic out_is_seg;
   assign out_is_seg = o_fld_idx >= SEG_FLD_BASE;

   a_cr_copy: assert property ( // RL1
      o_fld_valid && o_fld_idx == FLD_PT_BASE |-> o_fld_data == $past(i_page_table_base_reg))
      else $error("page table base not copied");

   a_fc_code_upper: assert property ( // RL2
      o_fld_valid && o_fld_idx == FLD_FC_CODE |-> o_fld_data[63:32] == 32'h0000_0000)
      else $error("fast-call selector upper half written");

   a_dbg_gate: assert property ( // RL3
      o_fld_valid && (o_fld_idx == FLD_DBG_REG || o_fld_idx == FLD_DBG_MSR)
      |-> save_reg[CTRL_SAVE_DBG])
      else $error("debug control saved while disabled");

   a_mm_base_gate: assert property ( // RL4
      o_fld_valid && o_fld_idx == FLD_MM_BASE |-> mm_reg)
      else $error("management base written on ordinary exit");

   a_cs_base_kept: assert property ( // RL6
      o_fld_valid && o_fld_idx == SEG_FLD_BASE |-> o_fld_data == $past(i_seg_base[SEG_CODE]))
      else $error("code segment base not saved");

   a_ss_upper_zero: assert property ( // RL7
      o_fld_valid && out_is_seg && seg_of(o_fld_idx) == SEG_STACK
      && kind_of(o_fld_idx) == SEG_KIND_BASE && $past(i_seg_unusable[SEG_STACK]) && LONG_MODE
      |-> o_fld_data[63:32] == 32'h0000_0000)
      else $error("unusable stack base upper half not zero");

   a_ar_format: assert property ( // RL10
      o_fld_valid && out_is_seg && kind_of(o_fld_idx) == SEG_KIND_AR
      |-> o_fld_data[31:17] == 15'h0000 && o_fld_data[11:8] == 4'h0
      && o_fld_data[16] == $past(i_seg_unusable[seg_of(o_fld_idx)]))
      else $error("access rights format wrong");

   a_gdt_limit: assert property ( // RL11
      o_fld_valid && o_fld_idx == FLD_GDT_LIMIT |-> o_fld_data[31:0] == $past(i_gdt_limit))
      else $error("descriptor table limit not saved");

   a_rip_instr: assert property ( // RL12
      o_fld_valid && o_fld_idx == FLD_INSTR_PTR && cause_reg == CAUSE_INSTR
      |-> o_fld_data == $past(i_instruction_pointer))
      else $error("instruction pointer does not reference exiting instruction");

   a_rip_follow: assert property ( // RL17
      o_fld_valid && o_fld_idx == FLD_INSTR_PTR
      && (cause_reg == CAUSE_PRIO_DROP || cause_reg == CAUSE_APIC_WRITE)
      |-> o_fld_data == $past(i_instruction_pointer_next))
      else $error("instruction pointer not at following instruction");

   a_rf_instr_zero: assert property ( // RL20
      o_fld_valid && o_fld_idx == FLD_FLAGS && cause_reg == CAUSE_INSTR
      |-> !o_fld_data[RESUME_FLAG_BIT])
      else $error("resume flag not zero for instruction exit");

   a_rf_access_one: assert property ( // RL21
      o_fld_valid && o_fld_idx == FLD_FLAGS && !vect_reg
      && (cause_reg == CAUSE_APIC_ACCESS || cause_reg == CAUSE_NPT)
      |-> o_fld_data[RESUME_FLAG_BIT])
      else $error("resume flag not one for unvectored access exit");

   a_exit_done: assert property (
      seq_reg == SEQ_IDLE && i_exit_start |-> ##EXIT_DONE_DELAY o_done)
      else $error("save sequence did not finish on time");

   c_instr_exit: cover property (
      o_fld_valid && o_fld_idx == FLD_FLAGS && cause_reg == CAUSE_INSTR);
   c_unusable_ar: cover property (
      o_fld_valid && out_is_seg && kind_of(o_fld_idx) == SEG_KIND_AR && o_fld_data[16]);
   c_mm_exit: cover property (o_fld_valid && o_fld_idx == FLD_MM_BASE);
   c_ctrl_write: cover property (aw_rdy_reg && i_s_axi_awaddr == ADDR_CTRL);

endmodule : vegss_top

// ===== test/vegss_top_tb.sv
`timescale 1ns/100ps
`define CHK(g, e) begin comparisons++; if ((g) !== (e)) begin failures++; \
   $display("MISMATCH t=%0t got=%h exp=%h", $time, (g), (e)); end end
module vegss_top_tb
   import vegss_pkg::*;
;
   logic i_core_clk, i_sys_rst, i_s_axi_awvalid, i_s_axi_wvalid, i_s_axi_bready;
   logic i_s_axi_arvalid, i_s_axi_rready, o_s_axi_awready, o_s_axi_wready;
   logic o_s_axi_bvalid, o_s_axi_arready, o_s_axi_rvalid;
   logic [7:0] i_s_axi_awaddr, i_s_axi_araddr;
   logic [31:0] i_s_axi_wdata, o_s_axi_rdata;
   logic [3:0] i_s_axi_wstrb, i_exit_cause;
   logic [1:0] o_s_axi_bresp, o_s_axi_rresp, r;
   logic i_exit_start, i_mm_exit, i_vect_info_valid, i_resume_flag_delivered;
   logic [63:0] cr0, ptb, cr4, fcc, fcs, fce, dr, dm, pat, efer, mmb, gdtb, idtb;
   logic [63:0] ip, ipn, ipr, sp, fl;
   logic [31:0] gdtl, idtl, rd;
   logic [63:0] i_seg_base [NUM_SEGS];
   logic [31:0] i_seg_limit [NUM_SEGS];
   logic [31:0] i_seg_ar [NUM_SEGS];
   logic [NUM_SEGS-1:0] i_seg_unusable;
   logic o_fld_valid, o_busy, o_done;
   logic [5:0] o_fld_idx;
   logic [63:0] o_fld_data;
   logic [63:0] got [42];
   logic [41:0] seen;
   int failures = 0;
   int comparisons = 0;

   vegss_top vegss_top_i (.i_core_clk(i_core_clk), .i_sys_rst(i_sys_rst),
      .i_s_axi_awaddr(i_s_axi_awaddr), .i_s_axi_awvalid(i_s_axi_awvalid),
      .o_s_axi_awready(o_s_axi_awready), .i_s_axi_wdata(i_s_axi_wdata),
      .i_s_axi_wstrb(i_s_axi_wstrb), .i_s_axi_wvalid(i_s_axi_wvalid),
      .o_s_axi_wready(o_s_axi_wready), .o_s_axi_bresp(o_s_axi_bresp),
      .o_s_axi_bvalid(o_s_axi_bvalid), .i_s_axi_bready(i_s_axi_bready),
      .i_s_axi_araddr(i_s_axi_araddr), .i_s_axi_arvalid(i_s_axi_arvalid),
      .o_s_axi_arready(o_s_axi_arready), .o_s_axi_rdata(o_s_axi_rdata),
      .o_s_axi_rresp(o_s_axi_rresp), .o_s_axi_rvalid(o_s_axi_rvalid),
      .i_s_axi_rready(i_s_axi_rready), .i_exit_start(i_exit_start),
      .i_exit_cause(i_exit_cause), .i_mm_exit(i_mm_exit),
      .i_vect_info_valid(i_vect_info_valid), .i_control_reg_zero(cr0),
      .i_page_table_base_reg(ptb), .i_control_reg_four(cr4),
      .i_fast_call_code_selector(fcc), .i_fast_call_stack_pointer(fcs),
      .i_fast_call_entry_pointer(fce), .i_debug_control_reg(dr),
      .i_debug_control_msr(dm), .i_page_attribute_msr(pat),
      .i_extended_feature_enable_msr(efer), .i_management_mode_base(mmb),
      .i_seg_base(i_seg_base), .i_seg_limit(i_seg_limit), .i_seg_ar(i_seg_ar),
      .i_seg_unusable(i_seg_unusable), .i_gdt_base(gdtb), .i_gdt_limit(gdtl),
      .i_idt_base(idtb), .i_idt_limit(idtl), .i_instruction_pointer(ip),
      .i_instruction_pointer_next(ipn), .i_instruction_pointer_return(ipr),
      .i_stack_pointer(sp), .i_flags_register(fl),
      .i_resume_flag_delivered(i_resume_flag_delivered), .o_fld_valid(o_fld_valid),
      .o_fld_idx(o_fld_idx), .o_fld_data(o_fld_data), .o_busy(o_busy), .o_done(o_done));

   initial begin
      i_core_clk = 1'b0;
      forever #2 i_core_clk = ~i_core_clk;
   end

   // collects every field written by the save sequence
   always @(posedge i_core_clk) begin
      if (i_exit_start) seen <= '0;
      if (o_fld_valid === 1'b1) begin
         got[o_fld_idx] <= o_fld_data;
         seen[o_fld_idx] <= 1'b1;
      end
   end

   task automatic axi_wr(input logic [7:0] a, input logic [31:0] d);
      int n;
      begin
         n = 0;
         i_s_axi_awaddr <= a; i_s_axi_wdata <= d; i_s_axi_awvalid <= 1'b1;
         i_s_axi_wvalid <= 1'b1; i_s_axi_wstrb <= 4'hf; i_s_axi_bready <= 1'b1;
         do @(posedge i_core_clk); while (o_s_axi_awready !== 1'b1 && ++n < 100);
         i_s_axi_awvalid <= 1'b0; i_s_axi_wvalid <= 1'b0;
         do @(posedge i_core_clk); while (o_s_axi_bvalid !== 1'b1 && ++n < 100);
         r = o_s_axi_bresp;
         `CHK(n < 100, 1'b1)
         i_s_axi_bready <= 1'b0;
      end
   endtask : axi_wr

   task automatic axi_rd(input logic [7:0] a);
      int n;
      begin
         n = 0;
         i_s_axi_araddr <= a; i_s_axi_arvalid <= 1'b1; i_s_axi_rready <= 1'b1;
         do @(posedge i_core_clk); while (o_s_axi_arready !== 1'b1 && ++n < 100);
         i_s_axi_arvalid <= 1'b0;
         do @(posedge i_core_clk); while (o_s_axi_rvalid !== 1'b1 && ++n < 100);
         r = o_s_axi_rresp; rd = o_s_axi_rdata;
         `CHK(n < 100, 1'b1)
      end
   endtask : axi_rd

   task automatic do_exit(input logic [3:0] c, input logic mm, input logic v);
      int n;
      begin
         n = 0;
         i_exit_cause <= c; i_mm_exit <= mm; i_vect_info_valid <= v; i_exit_start <= 1'b1;
         @(posedge i_core_clk);
         i_exit_start <= 1'b0;
         @(posedge i_core_clk);
         `CHK(o_busy, 1'b1)
         do @(posedge i_core_clk); while (o_done !== 1'b1 && ++n < 100);
         `CHK({n < 100, o_busy}, 2'b10)
         @(posedge i_core_clk);
      end
   endtask : do_exit

   task automatic t_regs;
      axi_rd(ADDR_CTRL); `CHK(rd[2:0], CTRL_RST)
      axi_rd(8'h40); `CHK({r, rd}, {RESP_SLVERR, 32'h0000_0000})
      axi_wr(ADDR_EXITS, 32'h0000_1234); axi_rd(ADDR_EXITS); `CHK(rd, 32'h0000_0000)
      $display("test regs done");
   endtask : t_regs

   task automatic t_usable;
      logic [63:0] e [18];
      int b;
      begin
         e = '{cr0, ptb, cr4, {32'h0000_0000, fcc[31:0]}, fcs, fce, dr, dm, pat, efer, mmb,
            gdtb, {32'h0000_0000, gdtl}, idtb, {32'h0000_0000, idtl}, ip, sp,
            fl & ~64'h0001_0000};
         do_exit(CAUSE_INSTR, 1'b0, 1'b0);
         for (int i = 0; i < 18; i++) if (i != 10) `CHK({seen[i], got[i]}, {1'b1, e[i]})
         for (int k = 0; k < 8; k++) begin
            b = int'(SEG_FLD_BASE) + 3 * k;
            `CHK(got[b], i_seg_base[k])
            `CHK({got[b+1][31:0], got[b+2][31:0]}, {i_seg_limit[k], 32'h0000_F0FF})
         end
         $display("test usable done");
      end
   endtask : t_usable

   task automatic t_unusable;
      int b;
      begin
         axi_wr(ADDR_CTRL, 32'h0000_0000); `CHK(r, RESP_OKAY)
         i_seg_unusable <= 8'hFF; fl <= 64'h0000_0202;
         do_exit(CAUSE_NPT, 1'b0, 1'b0);
         `CHK(seen[10:6], 5'h00)
         `CHK(got[17], 64'h0001_0202)
         for (int k = 0; k < 8; k++) begin
            b = int'(SEG_FLD_BASE) + 3 * k;
            `CHK(got[b+2] & 32'hFFFF_0F00, 32'h0001_0000)
            if (k >= 1 && k <= 3) `CHK(got[b][63:32], 32'h0000_0000)
            if (k == 0 || k == 4 || k == 5) `CHK(got[b], i_seg_base[k])
         end
         `CHK({got[19][31:0], got[20][15:13]}, {i_seg_limit[0], 3'h7})
         `CHK(got[21+2] & 32'h0000_0060, 32'h0000_0060)
         `CHK((&got[36][63:47]) | (~|got[36][63:47]), 1'b1)
         i_seg_unusable <= 8'h00; fl <= 64'h0000_0246;
         axi_wr(ADDR_CTRL, 32'h0000_0007);
         $display("test unusable done");
      end
   endtask : t_unusable

   task automatic t_causes;
      logic [63:0] eip;
      logic [12:0] rfmap;
      begin
         rfmap = 13'h0CF8;
         i_resume_flag_delivered <= 1'b1;
         for (int c = 0; c < 13; c++) begin
            do_exit(c[3:0], c == 1, 1'b0);
            case (c)
               3, 4, 7: eip = ipr;
               8, 9: eip = ipn;
               default: eip = ip;
            endcase
            `CHK(got[15], eip)
            `CHK(got[17][16], rfmap[c])
            `CHK(seen[10], c == 1)
         end
         i_resume_flag_delivered <= 1'b0;
         do_exit(CAUSE_APIC_ACCESS, 1'b0, 1'b1);
         `CHK(got[17][16], 1'b0)
         axi_rd(ADDR_EXITS); `CHK(rd[15:0], 16'h0010)
         axi_rd(ADDR_STATUS);
         `CHK(rd, 32'h0000_000A)
         $display("test causes done");
      end
   endtask : t_causes

   task automatic conclude;
      $display("comparisons %0d failures %0d", comparisons, failures);
      if (failures == 0 && comparisons > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask : conclude

   initial begin
      i_sys_rst = 1'b1; i_s_axi_awvalid = 0; i_s_axi_wvalid = 0; i_s_axi_bready = 0;
      i_s_axi_arvalid = 0; i_s_axi_rready = 0; i_s_axi_awaddr = 0; i_s_axi_araddr = 0;
      i_s_axi_wdata = 0; i_s_axi_wstrb = 0; i_exit_cause = 0; i_exit_start = 0;
      i_mm_exit = 0; i_vect_info_valid = 0; i_resume_flag_delivered = 0;
      cr0 = 64'h5A5A_0000_0000_0031; ptb = 64'h0000_0001_2345_6000; cr4 = 64'h0000_0000_0000_2020;
      fcc = 64'hAAAA_BBBB_0000_0010; fcs = 64'hCCCC_DDDD_0000_0020; fce = 64'hEEEE_1111_0000_0030;
      dr = 64'h0000_0000_0000_0401; dm = 64'h0000_0000_0000_0003; pat = 64'h0007_0406_0007_0406;
      efer = 64'h0000_0000_0000_0D01; mmb = 64'h0000_0000_0003_0000; gdtb = 64'h1234_5678_9ABC_DEF0;
      idtb = 64'h0FED_CBA9_8765_4320; gdtl = 32'h0000_FFFF; idtl = 32'h0000_0FFF;
      ip = 64'h0000_0000_0000_1000; ipn = 64'h0000_0000_0000_1004; ipr = 64'h0000_0000_0000_2000;
      sp = 64'h0000_7FFF_FFFF_E000; fl = 64'h0001_0246; i_seg_unusable = 8'h00;
      for (int k = 0; k < 8; k++) begin
         i_seg_base[k] = 64'hFEDC_BA98_7654_3210 + k;
         i_seg_limit[k] = 32'h000F_FFF0 + k;
         i_seg_ar[k] = 32'hFFFF_FFFF;
      end
      repeat (16) @(posedge i_core_clk);
      i_sys_rst <= 1'b0;
      @(posedge i_core_clk);
      t_regs();
      t_usable();
      t_unusable();
      t_causes();
      conclude();
   end

   initial begin
      #20000;
      failures++;
      conclude();
   end
endmodule : vegss_top_tb
